// [src/cogo_defines.svh]
// register offsets, field positions, reset values and mode codes for the clock output override
`ifndef COGO_DEFINES_SVH
`define COGO_DEFINES_SVH

// register indexes as printed; the byte address on the bus is four times the index
`define COGO_IDX_ENABLE      12'h724
`define COGO_IDX_SEL_P       12'h725
`define COGO_IDX_CFG_P       12'h727
`define COGO_IDX_SEL_N       12'h728
`define COGO_IDX_CFG_N       12'h72A
`define COGO_IDX_GPO_VALUE   12'h0F0

// enable register bits
`define COGO_EN_P_BIT        0
`define COGO_EN_N_BIT        1
`define COGO_EN_MASK         8'h03

// bit-selection register fields
`define COGO_SEL_BIT_HI      14
`define COGO_SEL_BIT_LO      12
`define COGO_SEL_PAGE_HI     11
`define COGO_SEL_PAGE_LO     8
`define COGO_SEL_OFS_HI      6
`define COGO_SEL_OFS_LO      0
`define COGO_SEL_MASK        16'h7F7F

// config register mode field
`define COGO_CFG_MODE_HI     2
`define COGO_CFG_MODE_LO     0
`define COGO_CFG_MASK        8'h07
`define COGO_MODE_GPO        3'h1
`define COGO_MODE_STATUS     3'h3

// reset values
`define COGO_RST_ENABLE      8'h00
`define COGO_RST_SEL         16'h0000
`define COGO_RST_CFG         8'h01
`define COGO_RST_GPO_VALUE   24'h000000

// ahb-lite codes
`define COGO_HTRANS_NONSEQ   2'h2
`define COGO_HSIZE_WORD      3'h2
`define COGO_GPO_WIDTH       24

`endif

// [src/cogo_pkg.sv]
// types shared by the clock output override modules
package cogo_pkg;

	// layout of a bit-selection register
	typedef struct packed
	{
		logic       rsv15;
		logic [2:0] bitpos;
		logic [3:0] page;
		logic       rsv7;
		logic [6:0] offset;
	} cogo_sel_t;

	// pin behaviour once the override is on
	typedef enum logic [1:0]
	{
		COGO_PIN_GPO,
		COGO_PIN_STATUS,
		COGO_PIN_RESERVED
	} cogo_pin_kind_t;

endpackage

// [src/cogo_pin_if.sv]
// settings handed from the register block to one pin's override logic
`timescale 1ns/1ps
interface cogo_pin_if;
	logic                   enable;
	cogo_pkg::cogo_pin_kind_t kind;
	logic [2:0]             bitpos;
	logic                   gpo_level;
	logic [7:0]             mirror_byte;

	modport ctrl
	(
		output enable,
		output kind,
		output bitpos,
		output gpo_level,
		output mirror_byte
	);

	modport pin
	(
		input  enable,
		input  kind,
		input  bitpos,
		input  gpo_level,
		input  mirror_byte
	);
endinterface

// [src/cogo_pin_mux.sv]
// one output pin: divided clock or a registered override level
`timescale 1ns/1ps
module cogo_pin_mux
	import cogo_pkg::*;
(
	// clock and reset
	input  wire logic  i_core_clk,
	input  wire logic  i_srst,
	// settings
	cogo_pin_if.pin    cfg,
	// pin side
	input  wire logic  i_div_clk,
	output logic       o_pin
);

	logic override_level;
	logic next_override_level;

	// the mirrored bit is picked straight from the live byte, so no latching or stretching
	assign next_override_level = (cfg.kind == COGO_PIN_GPO)    ? cfg.gpo_level :
	                             (cfg.kind == COGO_PIN_STATUS) ? cfg.mirror_byte[cfg.bitpos] :
	                             1'b0;

	// one flop of delay keeps the override level glitch free
	always_ff @(posedge i_core_clk)
	begin
		if (i_srst)
			override_level <= 1'b0;
		else
			override_level <= next_override_level;
	end

	// the divided clock bypasses the flop: registering it would destroy the clock
	assign o_pin = cfg.enable ? override_level : i_div_clk;

endmodule

// [src/cogo_top.sv]
// clock output pin pair with general-purpose output override and ahb-lite registers
//
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/1ps

// Function
// - negative pin carries divided clock unless its override enable bit is set.
// - positive pin carries divided clock unless its override enable bit is set.
// - selector bits 14:12 pick the bit inside the observed host byte.
// - selector bits 11:8 pick the host register map page.
// - selector bits 6:0 pick the byte offset within that page.
// - mode 001 drives the general-purpose value bit at twice the output index, or the bit above it on the negative pin.
// - mode 011 drives a copy of the selected host register bit.
// - mode is config bits 2:0; other codes are reserved.
// - negative selector uses the same bit, page and offset layout.
module cogo_top
	import cogo_pkg::*;
#(
	parameter int OUTPUT_INDEX = 0
)
(
	// clock and reset
	input  wire logic        i_core_clk,
	input  wire logic        i_srst,
	// ahb-lite slave
	input  wire logic        i_hsel,
	input  wire logic [31:0] i_haddr,
	input  wire logic [1:0]  i_htrans,
	input  wire logic        i_hwrite,
	input  wire logic [2:0]  i_hsize,
	input  wire logic        i_hready,
	input  wire logic [31:0] i_hwdata,
	output logic      [31:0] o_hrdata,
	output logic             o_hreadyout,
	output logic             o_hresp,
	// host register map lookup for status mirroring
	output logic      [3:0]  o_mirror_page_p,
	output logic      [6:0]  o_mirror_offset_p,
	input  wire logic [7:0]  i_mirror_byte_p,
	output logic      [3:0]  o_mirror_page_n,
	output logic      [6:0]  o_mirror_offset_n,
	input  wire logic [7:0]  i_mirror_byte_n,
	// divided clocks in, pins out
	input  wire logic        i_div_clk_p,
	input  wire logic        i_div_clk_n,
	output logic             o_out_p,
	output logic             o_out_n
);

`include "cogo_defines.svh"

	// the gpo value bits for this pair; index wraps into the 24-bit value register
	localparam logic [4:0] GPO_IDX_P = 5'((2 * OUTPUT_INDEX) % `COGO_GPO_WIDTH);
	localparam logic [4:0] GPO_IDX_N = 5'((2 * OUTPUT_INDEX + 1) % `COGO_GPO_WIDTH);

	// registers
	logic [7:0]  pin_override_enable;
	cogo_sel_t   positive_pin_bit_selector;
	logic [7:0]  positive_pin_override_config;
	cogo_sel_t   negative_pin_bit_selector;
	logic [7:0]  negative_pin_override_config;
	logic [23:0] gpo_value;

	// captured address phase
	logic        wr_pending;
	logic [11:0] wr_index;
	logic        next_wr_pending;
	logic [31:0] next_hrdata;

	// byte address to register index; unaligned addresses never match
	function automatic logic [11:0] addr_index(input logic [31:0] addr);
		addr_index = addr[13:2];
	endfunction

	// classify a mode code; unknown codes fall into the reserved kind
	function automatic cogo_pin_kind_t mode_kind(input logic [7:0] cfg);
		logic [2:0] mode;
		mode = cfg[`COGO_CFG_MODE_HI:`COGO_CFG_MODE_LO];
		if (mode == `COGO_MODE_GPO)
			mode_kind = COGO_PIN_GPO;
		else if (mode == `COGO_MODE_STATUS)
			mode_kind = COGO_PIN_STATUS;
		else
			mode_kind = COGO_PIN_RESERVED;
	endfunction

	// address phase decode
	wire        addr_valid;
	wire        addr_ok;
	wire [11:0] addr_idx;
	wire        rd_take;
	wire        hit_enable;
	wire        hit_sel_p;
	wire        hit_cfg_p;
	wire        hit_sel_n;
	wire        hit_cfg_n;
	wire        hit_gpo;

	assign addr_valid = i_hsel && i_hready && i_htrans[1];
	assign addr_ok    = (i_haddr[1:0] == 2'h0) && (i_haddr[31:14] == 18'h00000);
	assign addr_idx   = addr_index(i_haddr);
	assign rd_take    = addr_valid && !i_hwrite;
	assign next_wr_pending = addr_valid && i_hwrite && addr_ok;

	// data phase write decode, from the captured index
	assign hit_enable = wr_pending && (wr_index == `COGO_IDX_ENABLE);
	assign hit_sel_p  = wr_pending && (wr_index == `COGO_IDX_SEL_P);
	assign hit_cfg_p  = wr_pending && (wr_index == `COGO_IDX_CFG_P);
	assign hit_sel_n  = wr_pending && (wr_index == `COGO_IDX_SEL_N);
	assign hit_cfg_n  = wr_pending && (wr_index == `COGO_IDX_CFG_N);
	assign hit_gpo    = wr_pending && (wr_index == `COGO_IDX_GPO_VALUE);

	// read mux: reserved bits and unmapped addresses read as zero
	always_comb
	begin
		next_hrdata = 32'h00000000;
		if (!addr_ok)
			next_hrdata = 32'h00000000;
		else if (addr_idx == `COGO_IDX_ENABLE)
			next_hrdata = {24'h000000, pin_override_enable};
		else if (addr_idx == `COGO_IDX_SEL_P)
			next_hrdata = {16'h0000, positive_pin_bit_selector};
		else if (addr_idx == `COGO_IDX_CFG_P)
			next_hrdata = {24'h000000, positive_pin_override_config};
		else if (addr_idx == `COGO_IDX_SEL_N)
			next_hrdata = {16'h0000, negative_pin_bit_selector};
		else if (addr_idx == `COGO_IDX_CFG_N)
			next_hrdata = {24'h000000, negative_pin_override_config};
		else if (addr_idx == `COGO_IDX_GPO_VALUE)
			next_hrdata = {8'h00, gpo_value};
	end

	// zero-wait slave: always ready, always okay
	assign o_hreadyout = 1'b1;
	assign o_hresp     = 1'b0;

	// address phase capture and read data, valid through the data phase
	always_ff @(posedge i_core_clk)
	begin
		if (i_srst)
		begin
			wr_pending <= 1'b0;
			wr_index   <= 12'h000;
			o_hrdata   <= 32'h00000000;
		end
		else
		begin
			wr_pending <= next_wr_pending;
			wr_index   <= addr_idx;
			if (rd_take)
				o_hrdata <= next_hrdata;
		end
	end

	// override enables; only the two pin bits exist
	always_ff @(posedge i_core_clk)
	begin
		if (i_srst)
			pin_override_enable <= `COGO_RST_ENABLE;
		else if (hit_enable)
			pin_override_enable <= i_hwdata[7:0] & `COGO_EN_MASK;
	end

	// selectors keep bit, page and offset; bits 15 and 7 stay zero
	always_ff @(posedge i_core_clk)
	begin
		if (i_srst)
		begin
			positive_pin_bit_selector <= `COGO_RST_SEL;
			negative_pin_bit_selector <= `COGO_RST_SEL;
		end
		else
		begin
			if (hit_sel_p)
				positive_pin_bit_selector <= i_hwdata[15:0] & `COGO_SEL_MASK;
			if (hit_sel_n)
				negative_pin_bit_selector <= i_hwdata[15:0] & `COGO_SEL_MASK;
		end
	end

	// mode configs; reserved codes are stored and read back but drive the pin low
	always_ff @(posedge i_core_clk)
	begin
		if (i_srst)
		begin
			positive_pin_override_config <= `COGO_RST_CFG;
			negative_pin_override_config <= `COGO_RST_CFG;
		end
		else
		begin
			if (hit_cfg_p)
				positive_pin_override_config <= i_hwdata[7:0] & `COGO_CFG_MASK;
			if (hit_cfg_n)
				negative_pin_override_config <= i_hwdata[7:0] & `COGO_CFG_MASK;
		end
	end

	// general-purpose output levels shared by all outputs of the device
	always_ff @(posedge i_core_clk)
	begin
		if (i_srst)
			gpo_value <= `COGO_RST_GPO_VALUE;
		else if (hit_gpo)
			gpo_value <= i_hwdata[23:0];
	end

	// lookup addresses come straight from the selectors so a rewrite takes effect at once
	assign o_mirror_page_p   = positive_pin_bit_selector.page;
	assign o_mirror_offset_p = positive_pin_bit_selector.offset;
	assign o_mirror_page_n   = negative_pin_bit_selector.page;
	assign o_mirror_offset_n = negative_pin_bit_selector.offset;

	// per-pin settings
	cogo_pin_if cfg_p ();
	cogo_pin_if cfg_n ();

	assign cfg_p.enable      = pin_override_enable[`COGO_EN_P_BIT];
	assign cfg_p.kind        = mode_kind(positive_pin_override_config);
	assign cfg_p.bitpos      = positive_pin_bit_selector.bitpos;
	assign cfg_p.gpo_level   = gpo_value[GPO_IDX_P];
	assign cfg_p.mirror_byte = i_mirror_byte_p;

	assign cfg_n.enable      = pin_override_enable[`COGO_EN_N_BIT];
	assign cfg_n.kind        = mode_kind(negative_pin_override_config);
	assign cfg_n.bitpos      = negative_pin_bit_selector.bitpos;
	assign cfg_n.gpo_level   = gpo_value[GPO_IDX_N];
	assign cfg_n.mirror_byte = i_mirror_byte_n;

	// positive pin
	cogo_pin_mux u_pin_p
	(
		.i_core_clk (i_core_clk),
		.i_srst     (i_srst),
		.cfg        (cfg_p),
		.i_div_clk  (i_div_clk_p),
		.o_pin      (o_out_p)
	);

	// negative pin
	cogo_pin_mux u_pin_n
	(
		.i_core_clk (i_core_clk),
		.i_srst     (i_srst),
		.cfg        (cfg_n),
		.i_div_clk  (i_div_clk_n),
		.o_pin      (o_out_n)
	);

endmodule

// [dv/cogo_checker.sv]
// concurrent checks on the clock output override ports
`timescale 1ns/1ps
module cogo_checker
#(
	parameter int OUTPUT_INDEX = 0
)
(
	// clock and reset
	input wire logic        i_core_clk,
	input wire logic        i_srst,
	// register bus
	input wire logic        i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0]  i_htrans,
	input wire logic        i_hwrite,
	input wire logic        i_hready,
	input wire logic [31:0] i_hwdata,
	input wire logic        o_hreadyout,
	input wire logic        o_hresp,
	// pins
	input wire logic [3:0]  o_mirror_page_p,
	input wire logic [6:0]  o_mirror_offset_p,
	input wire logic [7:0]  i_mirror_byte_p,
	input wire logic        i_div_clk_p,
	input wire logic        i_div_clk_n,
	input wire logic        o_out_p,
	input wire logic        o_out_n
);
	logic        wr_q;
	logic [31:0] a_q;
	logic [1:0]  en;
	logic [15:0] sel;
	logic [2:0]  md;
	logic [23:0] gp;
	wire         mbit = i_mirror_byte_p[sel[14:12]];
	wire         gbit = gp[2 * OUTPUT_INDEX];

	// shadow registers, written at the data phase edge just as the device's are
	always_ff @(posedge i_core_clk)
	begin
		wr_q <= !i_srst && i_hsel && i_hready && i_htrans[1] && i_hwrite;
		a_q  <= i_haddr;
		if (i_srst)
		begin
			en  <= 2'h0;
			sel <= 16'h0000;
			md  <= 3'h1;
			gp  <= 24'h000000;
		end
		else if (wr_q)
		begin
			if (a_q == 32'h1C90) en <= i_hwdata[1:0];
			if (a_q == 32'h1C94) sel <= i_hwdata[15:0];
			if (a_q == 32'h1C9C) md <= i_hwdata[2:0];
			if (a_q == 32'h3C0) gp <= i_hwdata[23:0];
		end
	end

	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (i_srst);

	// zero-wait slave, never an error response
	a_ready_high: assert property (o_hreadyout && !o_hresp)
		else $error("bus answer not ready or not okay");
	// a pin without override must show its divided clock at once
	a_div_clk_p: assert property (!en[0] |-> o_out_p == i_div_clk_p)
		else $error("positive pin not on divided clock");
	a_div_clk_n: assert property (!en[1] |-> o_out_n == i_div_clk_n)
		else $error("negative pin not on divided clock");
	a_lookup_addr: assert property (o_mirror_page_p == sel[11:8] && o_mirror_offset_p == sel[6:0])
		else $error("mirror lookup address wrong");
	// the override flop lags its source by one edge
	a_gpo_level: assert property (en[0] && md == 3'h1 && $past(md) == 3'h1 |-> o_out_p == $past(gbit))
		else $error("output value bit not on pin");
	a_mirror_bit: assert property (en[0] && md == 3'h3 && $past(md) == 3'h3 |-> o_out_p == $past(mbit))
		else $error("mirrored bit not on pin");
	a_rsv_low: assert property (en[0] && md != 3'h1 && md != 3'h3 && $stable(md) |-> !o_out_p)
		else $error("reserved mode not driving low");
	a_mirror_gap: assert property (en[0] && md == 3'h3 && $stable(md) && $changed(mbit) |=> o_out_p == $past(mbit))
		else $error("pin lags mirrored bit");
endmodule

bind cogo_top cogo_checker #(.OUTPUT_INDEX(OUTPUT_INDEX)) u_chk
(
	.i_core_clk, .i_srst, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hready, .i_hwdata, .o_hreadyout,
	.o_hresp, .o_mirror_page_p, .o_mirror_offset_p, .i_mirror_byte_p, .i_div_clk_p, .i_div_clk_n,
	.o_out_p, .o_out_n
);

// [dv/cogo_tb.sv]
// self-checking bench for the clock output override pin pair
`timescale 1ns/1ps
module testbench;
	logic        clk, srst, hsel, hwrite, dp, dn;
	logic [1:0]  htrans;
	logic [31:0] haddr, hwdata, rd, d, seed;
	logic [7:0]  mbp;
	wire  [31:0] hrdata;
	wire  [3:0]  pgp, pgn;
	wire  [6:0]  ofp, ofn;
	wire         rdy, resp, outp, outn;
	int          failures, num_checks;
	logic [31:0] adr [7] = '{32'h1C90, 32'h1C94, 32'h1C9C, 32'h1CA0, 32'h1CA8, 32'h3C0, 32'h1C98};
	logic [31:0] dfl [7] = '{32'h0, 32'h0, 32'h1, 32'h0, 32'h1, 32'h0, 32'h0};

	// device under test, word size only
	cogo_top #(.OUTPUT_INDEX(0)) dut
	(
		.i_core_clk(clk), .i_srst(srst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
		.i_hwrite(hwrite), .i_hsize(3'h2), .i_hready(rdy), .i_hwdata(hwdata), .o_hrdata(hrdata),
		.o_hreadyout(rdy), .o_hresp(resp), .o_mirror_page_p(pgp), .o_mirror_offset_p(ofp),
		.i_mirror_byte_p(mbp), .o_mirror_page_n(pgn), .o_mirror_offset_n(ofn), .i_mirror_byte_n(~mbp),
		.i_div_clk_p(dp), .i_div_clk_n(dn), .o_out_p(outp), .o_out_n(outn)
	);

	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	function automatic logic [31:0] nx(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// expected override level; reserved codes drive low
	function automatic logic lvl(input logic [2:0] m, input logic g, input logic s);
		return (m == 3'h1) ? g : (m == 3'h3) ? s : 1'b0;
	endfunction

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic end_sim;
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// bounded wait for hready at a rising edge
	task automatic hrdy;
		int n;
		n = 0;
		@(posedge clk);
		while (rdy !== 1'b1 && n < 20)
		begin
			n++;
			@(posedge clk);
		end
		if (n == 20) failures++;
	endtask

	// one single transfer; the leading edge keeps a gap so a read sees the last write
	task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] wd);
		@(posedge clk);
		hsel   <= 1'b1;
		haddr  <= a;
		htrans <= 2'h2;
		hwrite <= w;
		hrdy();
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		hrdy();
		rd = hrdata;
	endtask

	task automatic settle;
		repeat (2) @(posedge clk);
		@(negedge clk);
	endtask

	task automatic divchk;
		repeat (6)
		begin
			@(posedge clk);
			seed = nx(seed);
			dp <= seed[0];
			dn <= seed[1];
			@(negedge clk);
			chk("out_p", 32'(outp), 32'(dp));
			chk("out_n", 32'(outn), 32'(dn));
		end
	endtask

	initial
	begin
		#(3000 * 100);
		failures++;
		end_sim();
	end

	initial
	begin
		seed = 32'hED5CCB7E;
		failures = 0;
		num_checks = 0;
		srst = 1'b1;
		hsel = 1'b0;
		htrans = 2'h0;
		hwrite = 1'b0;
		haddr = 32'h0;
		hwdata = 32'h0;
		dp = 1'b0;
		dn = 1'b0;
		mbp = 8'h00;
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		// reset values, an unmapped word among them
		for (int i = 0; i < 7; i++)
		begin
			bus(adr[i], 1'b0, 32'h0);
			chk("reset", rd, dfl[i]);
		end
		divchk();
		$display("reset test done");
		for (int i = 0; i < 4; i++)
		begin
			seed = nx(seed);
			bus(32'h1C94, 1'b1, seed);
			bus(32'h1CA0, 1'b1, ~seed);
			bus(32'h1C94, 1'b0, 32'h0);
			chk("sel_p", rd, seed & 32'h7F7F);
			chk("page_p", 32'(pgp), 32'(seed[11:8]));
			chk("ofs_p", 32'(ofp), 32'(seed[6:0]));
			bus(32'h1CA0, 1'b0, 32'h0);
			chk("sel_n", rd, ~seed & 32'h7F7F);
			chk("page_n", 32'(pgn), {28'h0000000, ~seed[11:8]});
			chk("ofs_n", 32'(ofn), {25'h0000000, ~seed[6:0]});
		end
		$display("selector test done");
		bus(32'h1C90, 1'b1, 32'hFF);
		bus(32'h1C90, 1'b0, 32'h0);
		chk("enable", rd, 32'h3);
		bus(32'h1CA8, 1'b1, 32'h1);
		for (int i = 0; i < 4; i++)
		begin
			seed = nx(seed);
			bus(32'h3C0, 1'b1, seed);
			settle();
			chk("gpo_p", 32'(outp), 32'(lvl(3'h1, seed[0], 1'b0)));
			chk("gpo_n", 32'(outn), 32'(seed[1]));
		end
		$display("output value test done");
		for (int b = 0; b < 8; b++)
		begin
			seed = nx(seed);
			d = (seed & 32'h0F7F) | (32'(b) << 12);
			bus(32'h1C94, 1'b1, d);
			bus(32'h1CA0, 1'b1, d);
			if (b == 0) bus(32'h1C9C, 1'b1, 32'h3);
			if (b == 0) bus(32'h1CA8, 1'b1, 32'h3);
			@(posedge clk);
			mbp <= seed[23:16];
			settle();
			chk("stat", 32'(outp), 32'(lvl(3'h3, 1'b0, seed[16 + b])));
			chk("stat_n", 32'(outn), 32'(lvl(3'h3, 1'b0, ~seed[16 + b])));
			@(posedge clk);
			mbp <= ~seed[23:16];
			settle();
			chk("follow", 32'(outp), 32'(lvl(3'h3, 1'b0, ~seed[16 + b])));
			chk("follow_n", 32'(outn), 32'(lvl(3'h3, 1'b0, seed[16 + b])));
		end
		$display("status test done");
		bus(32'h3C0, 1'b1, 32'hFFFFFF);
		for (int m = 0; m < 8; m++)
		begin
			if (m == 1 || m == 3) continue;
			bus(32'h1C9C, 1'b1, 32'hF8 | 32'(m));
			settle();
			chk("rsv_pin", 32'(outp), 32'(lvl(3'(m), 1'b1, 1'b1)));
			bus(32'h1C9C, 1'b0, 32'h0);
			chk("cfg", rd, 32'(m));
		end
		$display("reserved test done");
		bus(32'h1C90, 1'b1, 32'h0);
		divchk();
		$display("disable test done");
		end_sim();
	end
endmodule
